// ===== logic/nv_access_pkg.sv
package nv_access_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_DATA = 8'h9a;
  localparam logic [7:0] IDX_ADDR = 8'h9b;
  localparam logic [7:0] IDX_CTRL = 8'h9c;
  localparam logic [7:0] IDX_KEY = 8'h9d;
  localparam logic [7:0] IDX_PFLAG = 8'h0c;

  // control register and peripheral flag register bit positions
  localparam int CTRL_RD = 0;
  localparam int CTRL_WR = 1;
  localparam int CTRL_PERMIT = 2;
  localparam int CTRL_ABORT = 3;
  localparam int PFLAG_DONE = 7;

  // unlock keys, erased cell value and reset values
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [6:0] ADDR_RESET = 7'h00;
  localparam logic [31:0] HRDATA_RESET = 32'h0000_0000;
  localparam logic HRESP_OKAY = 1'b0;

  // array geometry
  localparam int ADDR_W = 7;
  localparam int ARRAY_DEPTH = 128;

  // timing: power-up timer in ms, converted at the core clock rate
  localparam int CLK_MHZ = 125;
  localparam int PWRT_MS = 72;
  localparam int PWRT_CYCLES = PWRT_MS * 1000 * CLK_MHZ;
  localparam int PWRT_W = 24;
  localparam int WRITE_CYCLES_DEF = 40;
  localparam int WCNT_W = 16;

  // unlock sequence tracker states
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_FIRST = 3'b010,
    SEQ_SECOND = 3'b100
  } unlock_state_t;

endpackage : nv_access_pkg

// ===== logic/nv_mem_if.sv
`timescale 1ns/1ps
// write and read port of the byte array
interface nv_mem_if;
  logic we;
  logic [6:0] waddr;
  logic [7:0] wdata;
  logic [6:0] raddr;
  logic [7:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport array (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : nv_mem_if

// ===== logic/nv_array.sv
`timescale 1ns/1ps
module nv_array (
  input wire logic clk,
  nv_mem_if.array port
);

  logic [7:0] cells [nv_access_pkg::ARRAY_DEPTH];
  logic [7:0] rdata_q;

  // cells keep their content across resets, so no reset here
  always_ff @(posedge clk) begin
    if (port.we) begin
      cells[port.waddr] <= port.wdata;
    end
    rdata_q <= cells[port.raddr];
  end

  assign port.rdata = rdata_q;

endmodule : nv_array

// ===== logic/nv_unlock_seq.sv
`timescale 1ns/1ps
module nv_unlock_seq (
  input wire logic clk,
  input wire logic reset,
  input wire logic clear,
  input wire logic xferValid,
  input wire logic keyWrite,
  input wire logic [7:0] keyByte,
  output logic armed
);

  nv_access_pkg::unlock_state_t state_q;
  nv_access_pkg::unlock_state_t state_d;
  logic firstKey;
  logic secondKey;

  assign firstKey = keyWrite && (keyByte == nv_access_pkg::KEY_FIRST);
  assign secondKey = keyWrite && (keyByte == nv_access_pkg::KEY_SECOND);

  // every bus transfer is one step; any stray transfer breaks the count
  always_comb begin
    state_d = state_q;
    if (xferValid) begin
      case (state_q)
        nv_access_pkg::SEQ_IDLE: begin
          state_d = firstKey ? nv_access_pkg::SEQ_FIRST : nv_access_pkg::SEQ_IDLE;
        end
        nv_access_pkg::SEQ_FIRST: begin
          state_d = secondKey ? nv_access_pkg::SEQ_SECOND :
                    firstKey ? nv_access_pkg::SEQ_FIRST : nv_access_pkg::SEQ_IDLE; // RULE9
        end
        default: begin
          state_d = firstKey ? nv_access_pkg::SEQ_FIRST : nv_access_pkg::SEQ_IDLE; // RULE10
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset || clear) begin
      state_q <= nv_access_pkg::SEQ_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign armed = (state_q == nv_access_pkg::SEQ_SECOND);

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  key_order_a: assert property ($rose(armed) |-> $past(xferValid && secondKey)) // RULE9
    else $error("armed without second key");
  key_spacing_a: assert property (armed && xferValid |=> !armed) // RULE10
    else $error("arm survived an extra transfer");

endmodule : nv_unlock_seq

// ===== logic/data_eeprom_access_ctrl.sv
`timescale 1ns/1ps
//
// Contract
// RULE1 - address uses low seven bits only
// RULE2 - software keeps address top bit zero
// RULE3 - control upper four bits read zero
// RULE4 - triggers only set by software, hardware clears
// RULE5 - read fetches byte in one cycle
// RULE6 - data register holds until read or write
// RULE7 - write trigger ignored without write permit
// RULE8 - write permit changed only by software
// RULE9 - unlock needs 55h, AAh, then trigger
// RULE10 - exact transfer count across unlock sequence
// RULE11 - clearing permit never aborts running write
// RULE12 - completion clears trigger, sets done flag
// RULE13 - interrupted write sets abort flag
// RULE14 - aborting reset clears data and address
// RULE15 - unlock port stores nothing, reads zero
// RULE16 - no writes while power-up timer runs
// RULE17 - software disables interrupts during unlock
// RULE18 - each byte write erases first
// RULE19 - write length set by internal timer
// RULE20 - write duration parameter, trigger held throughout
module data_eeprom_access_ctrl #(
  parameter int PowerupCycles = nv_access_pkg::PWRT_CYCLES,
  parameter int WriteCycles = nv_access_pkg::WRITE_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic externalResetPinN,
  input wire logic watchdogTimeout,
  input wire logic brownoutDetect,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic writeBusy,
  output logic writeDoneFlag,
  output logic writeAbortFlag
);

  // bus side state
  logic hreadyout_q;
  logic hresp_q;
  logic [31:0] hrdata_q;
  logic pendValid_q;
  logic pendWrite_q;
  logic pendMapped_q;
  logic [7:0] pendIdx_q;

  // register state
  logic [6:0] nvAddr_q;
  logic [7:0] nvData_q;
  logic rdPend_q;
  logic permit_q;
  logic abortFlag_q;
  logic doneFlag_q;
  logic wrBusy_q;
  logic [nv_access_pkg::WCNT_W-1:0] wrCnt_q;
  logic [6:0] wrAddr_q;
  logic [7:0] wrData_q;
  logic pwrtRun_q;
  logic [nv_access_pkg::PWRT_W-1:0] pwrtCnt_q;

  // decode wires
  logic addrPhase;
  logic [7:0] addrIdx;
  logic addrInRange;
  logic addrMapped;
  logic commit;
  logic selData;
  logic selAddr;
  logic selCtrl;
  logic selKey;
  logic selPflag;
  logic wrDataReg;
  logic wrAddrReg;
  logic wrCtrlReg;
  logic wrPflagReg;
  logic rdAccess;
  logic [7:0] wByte;
  logic [7:0] ctrlByte;
  logic [7:0] readByte;
  logic seqArmed;
  logic startWrite;
  logic finishWrite;
  logic abortNow;
  logic [2:0] rstReqRaw;
  logic [2:0] rstReq;
  logic resetEvt;

  nv_mem_if memBus ();

  nv_array u_array (
    .clk(clk),
    .port(memBus.array)
  );

  nv_unlock_seq u_unlock (
    .clk(clk),
    .reset(reset),
    .clear(resetEvt),
    .xferValid(commit),
    .keyWrite(selKey && pendWrite_q),
    .keyByte(wByte),
    .armed(seqArmed)
  );

  // reset sources come from other domains: two flops each, first read only by second
  assign rstReqRaw = {brownoutDetect, watchdogTimeout, ~externalResetPinN};

  generate
    for (genvar i = 0; i < 3; i++) begin : g_sync
      logic meta_q;
      logic stable_q;
      always_ff @(posedge clk) begin
        if (reset) begin
          meta_q <= 1'b0;
          stable_q <= 1'b0;
        end else begin
          meta_q <= rstReqRaw[i];
          stable_q <= meta_q;
        end
      end
      assign rstReq[i] = stable_q;
    end
  endgenerate

  // any external, watchdog or brown-out reset acts as a level while held
  assign resetEvt = |rstReq;

  // address phase decode; only word-aligned addresses in the low 1 KiB are mapped, hsize is not checked
  assign addrPhase = hsel && htrans[1] && hready;
  assign addrIdx = haddr[9:2];
  assign addrInRange = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
  assign addrMapped = addrInRange &&
                      ((addrIdx == nv_access_pkg::IDX_DATA) ||
                       (addrIdx == nv_access_pkg::IDX_ADDR) ||
                       (addrIdx == nv_access_pkg::IDX_CTRL) ||
                       (addrIdx == nv_access_pkg::IDX_KEY) ||
                       (addrIdx == nv_access_pkg::IDX_PFLAG));

  // one wait state per transfer so read data always sees the last write
  always_ff @(posedge clk) begin
    if (reset) begin
      pendValid_q <= 1'b0;
      pendWrite_q <= 1'b0;
      pendMapped_q <= 1'b0;
      pendIdx_q <= 8'h00;
      hreadyout_q <= 1'b1;
      hresp_q <= nv_access_pkg::HRESP_OKAY;
    end else begin
      pendValid_q <= addrPhase;
      hreadyout_q <= !addrPhase;
      hresp_q <= nv_access_pkg::HRESP_OKAY;
      if (addrPhase) begin
        pendWrite_q <= hwrite;
        pendMapped_q <= addrMapped;
        pendIdx_q <= addrIdx;
      end
    end
  end

  // data phase selects; unmapped reads give zero, unmapped writes vanish
  assign commit = pendValid_q;
  assign selData = commit && pendMapped_q && (pendIdx_q == nv_access_pkg::IDX_DATA);
  assign selAddr = commit && pendMapped_q && (pendIdx_q == nv_access_pkg::IDX_ADDR);
  assign selCtrl = commit && pendMapped_q && (pendIdx_q == nv_access_pkg::IDX_CTRL);
  assign selKey = commit && pendMapped_q && (pendIdx_q == nv_access_pkg::IDX_KEY);
  assign selPflag = commit && pendMapped_q && (pendIdx_q == nv_access_pkg::IDX_PFLAG);
  assign wrDataReg = selData && pendWrite_q;
  assign wrAddrReg = selAddr && pendWrite_q;
  assign wrCtrlReg = selCtrl && pendWrite_q;
  assign wrPflagReg = selPflag && pendWrite_q;
  assign rdAccess = commit && !pendWrite_q;
  assign wByte = hwdata[7:0];

  // read mux; the key port has no storage and always answers zero
  assign ctrlByte = {4'h0, abortFlag_q, permit_q, wrBusy_q, rdPend_q}; // RULE3
  assign readByte = selData ? nvData_q :
                    selAddr ? {1'b0, nvAddr_q} : // RULE1
                    selCtrl ? ctrlByte :
                    selPflag ? {doneFlag_q, 7'h00} :
                    8'h00; // RULE15

  always_ff @(posedge clk) begin
    if (reset) begin
      hrdata_q <= nv_access_pkg::HRDATA_RESET;
    end else if (rdAccess) begin
      hrdata_q <= {24'h000000, readByte};
    end
  end

  // write start needs permit already set, unlock armed and power-up done
  assign startWrite = wrCtrlReg && wByte[nv_access_pkg::CTRL_WR] && permit_q && // RULE7
                      seqArmed && !pwrtRun_q && !wrBusy_q && !resetEvt; // RULE9 RULE16
  assign finishWrite = wrBusy_q && (wrCnt_q == '0) && !resetEvt; // RULE19
  assign abortNow = resetEvt && wrBusy_q;

  // address register: the top bit is never stored
  always_ff @(posedge clk) begin
    if (reset || resetEvt) begin
      nvAddr_q <= nv_access_pkg::ADDR_RESET; // RULE14
    end else if (wrAddrReg) begin
      nvAddr_q <= wByte[6:0]; // RULE1
    end
  end

  // data register: loaded by a finished read or by software only
  always_ff @(posedge clk) begin
    if (reset || resetEvt) begin
      nvData_q <= nv_access_pkg::DATA_RESET; // RULE14
    end else if (rdPend_q) begin
      nvData_q <= memBus.rdata; // RULE5
    end else if (wrDataReg) begin
      nvData_q <= wByte; // RULE6
    end
  end

  // read trigger: set by software, cleared by hardware one cycle later
  always_ff @(posedge clk) begin
    if (reset || resetEvt) begin
      rdPend_q <= 1'b0;
    end else begin
      rdPend_q <= wrCtrlReg && wByte[nv_access_pkg::CTRL_RD]; // RULE4 RULE5
    end
  end

  // write permit: clear on resets, otherwise only software moves it
  always_ff @(posedge clk) begin
    if (reset || resetEvt) begin
      permit_q <= 1'b0;
    end else if (wrCtrlReg) begin
      permit_q <= wByte[nv_access_pkg::CTRL_PERMIT]; // RULE8
    end
  end

  // abort flag: a cut-short write sets it, and the set beats a software clear
  always_ff @(posedge clk) begin
    if (reset) begin
      abortFlag_q <= 1'b0;
    end else if (abortNow) begin
      abortFlag_q <= 1'b1; // RULE13
    end else if (wrCtrlReg) begin
      abortFlag_q <= wByte[nv_access_pkg::CTRL_ABORT];
    end
  end

  // done flag: completion wins over a software clear in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      doneFlag_q <= 1'b0;
    end else if (finishWrite) begin
      doneFlag_q <= 1'b1; // RULE12
    end else if (resetEvt) begin
      doneFlag_q <= 1'b0;
    end else if (wrPflagReg) begin
      doneFlag_q <= wByte[nv_access_pkg::PFLAG_DONE];
    end
  end

  // write trigger stays set for the timed cycle; software cannot clear it
  always_ff @(posedge clk) begin
    if (reset || resetEvt) begin
      wrBusy_q <= 1'b0;
    end else if (startWrite) begin
      wrBusy_q <= 1'b1; // RULE20
    end else if (finishWrite) begin
      wrBusy_q <= 1'b0; // RULE4 RULE12
    end
  end

  // write timer and latched target; permit changes no longer matter here
  always_ff @(posedge clk) begin
    if (reset) begin
      wrCnt_q <= '0;
      wrAddr_q <= nv_access_pkg::ADDR_RESET;
      wrData_q <= nv_access_pkg::DATA_RESET;
    end else if (startWrite) begin
      wrCnt_q <= nv_access_pkg::WCNT_W'(WriteCycles - 1); // RULE20
      wrAddr_q <= nvAddr_q;
      wrData_q <= nvData_q; // RULE11
    end else if (wrBusy_q && (wrCnt_q != '0)) begin
      wrCnt_q <= wrCnt_q - 1'b1; // RULE19
    end
  end

  // power-up timer runs only after power-on reset, not the other resets
  always_ff @(posedge clk) begin
    if (reset) begin
      pwrtRun_q <= 1'b1;
      pwrtCnt_q <= '0;
    end else if (pwrtRun_q) begin
      if (pwrtCnt_q == nv_access_pkg::PWRT_W'(PowerupCycles - 1)) begin
        pwrtRun_q <= 1'b0; // RULE16
      end else begin
        pwrtCnt_q <= pwrtCnt_q + 1'b1;
      end
    end
  end

  // array port: erase at start, program at the end; an abort leaves it erased
  assign memBus.we = startWrite || finishWrite;
  assign memBus.waddr = startWrite ? nvAddr_q : wrAddr_q;
  assign memBus.wdata = startWrite ? nv_access_pkg::ERASED_BYTE : wrData_q; // RULE18
  assign memBus.raddr = nvAddr_q;

  // outputs straight from flops
  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign writeBusy = wrBusy_q;
  assign writeDoneFlag = doneFlag_q;
  assign writeAbortFlag = abortFlag_q;

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  addr_top_zero_a: assert property (rdAccess && selAddr |=> hrdata[7] == 1'b0) // RULE1
    else $error("address top bit read back set");
  ctrl_upper_zero_a: assert property (rdAccess && selCtrl |=> hrdata[7:4] == 4'h0) // RULE3
    else $error("control upper bits not zero");
  read_one_cycle_a: assert property (rdPend_q && !resetEvt |=>
      !rdPend_q && nvData_q == $past(memBus.rdata)) // RULE5
    else $error("read did not complete in one cycle");
  data_holds_a: assert property (!rdPend_q && !wrDataReg && !resetEvt |=>
      $stable(nvData_q)) // RULE6
    else $error("data register changed without cause");
  write_permit_a: assert property ($rose(wrBusy_q) |->
      $past(permit_q) && !$past(pwrtRun_q)) // RULE7
    else $error("write started without permit");
  permit_sticky_a: assert property (permit_q && !wrCtrlReg && !resetEvt |=> permit_q) // RULE8
    else $error("permit cleared by hardware");
  write_holds_a: assert property (wrBusy_q && wrCnt_q != '0 && !resetEvt |=> wrBusy_q) // RULE11
    else $error("write cycle ended early");
  done_sets_flag_a: assert property (finishWrite |=> doneFlag_q && !wrBusy_q) // RULE12
    else $error("completion not flagged");
  abort_clears_a: assert property (abortNow |=>
      abortFlag_q && nvData_q == 8'h00 && nvAddr_q == 7'h00) // RULE13 RULE14
    else $error("abort not recorded");
  key_reads_zero_a: assert property (rdAccess && selKey |=> hrdata == 32'h0) // RULE15
    else $error("key port read nonzero");
  pwrt_blocks_a: assert property (pwrtRun_q |=> !$rose(wrBusy_q)) // RULE16
    else $error("write during power-up timer");
  erase_first_a: assert property (startWrite |-> memBus.we &&
      memBus.wdata == nv_access_pkg::ERASED_BYTE) // RULE18
    else $error("write did not erase first");
  write_length_a: assert property ($rose(wrBusy_q) |->
      wrCnt_q == nv_access_pkg::WCNT_W'(WriteCycles - 1)) // RULE20
    else $error("write timer loaded wrong");

  read_seen_c: cover property (rdPend_q ##1 rdAccess && selData);
  write_done_c: cover property (startWrite ##[1:300] finishWrite);
  write_abort_c: cover property (wrBusy_q ##1 abortNow);
  done_clear_c: cover property (doneFlag_q && wrPflagReg && !wByte[7]);

endmodule : data_eeprom_access_ctrl

// ===== bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam int PwrCyc = 20;
  localparam int WrCyc = 8;
  localparam logic [31:0] ADDR_DATA = 32'h0000_0268;
  localparam logic [31:0] ADDR_ADDR = 32'h0000_026c;
  localparam logic [31:0] ADDR_CTRL = 32'h0000_0270;
  localparam logic [31:0] ADDR_KEY = 32'h0000_0274;
  localparam logic [31:0] ADDR_PFLAG = 32'h0000_0030;
  logic clk, reset, hsel, hwrite, extRstN, wdog, brown;
  logic [31:0] haddr, hwdata, hrdata, rdVal;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, writeBusy, writeDoneFlag, writeAbortFlag;
  int fail_count, tests_run, busyMark;
  int busyCount = 0;

  data_eeprom_access_ctrl #(.PowerupCycles(PwrCyc), .WriteCycles(WrCyc)) uut (
    .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .externalResetPinN(extRstN), .watchdogTimeout(wdog), .brownoutDetect(brown),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .writeBusy(writeBusy),
    .writeDoneFlag(writeDoneFlag), .writeAbortFlag(writeAbortFlag)
  );

  // free-running core clock
  always #4 clk = ~clk;

  // count busy cycles at the falling edge, away from the launching edge
  always @(negedge clk) begin
    if (writeBusy === 1'b1) busyCount++;
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one single AHB-Lite transfer; caller sits just after a rising edge
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    int n;
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'b00;
    hwdata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    rdVal = hrdata;
    if (n >= 100) begin
      fail_count++;
      summarize();
    end
    chk({31'h0, hresp}, 32'h0);
  endtask : xfer

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h0, d});
  endtask : wr

  // read one register and compare the word with what is expected
  task automatic rdChk(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rdVal, exp);
  endtask : rdChk

  // full unlock sequence; busy cycles counted from just before the trigger
  task automatic writeByte(input logic [7:0] a, input logic [7:0] d);
    wr(ADDR_ADDR, a);
    wr(ADDR_DATA, d);
    wr(ADDR_CTRL, 8'h04);
    wr(ADDR_KEY, nv_access_pkg::KEY_FIRST);
    wr(ADDR_KEY, nv_access_pkg::KEY_SECOND);
    busyMark = busyCount;
    wr(ADDR_CTRL, 8'h06);
  endtask : writeByte

  task automatic waitIdle();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (writeBusy !== 1'b0 && n < 200);
    if (n >= 200) begin
      fail_count++;
      summarize();
    end
  endtask : waitIdle

  // a proper unlock while the power-up timer still runs must not start
  task automatic scenEarlyWrite();
    writeByte(8'h00, 8'h00);
    repeat (3) @(posedge clk);
    chk(32'(busyCount - busyMark), 32'h0);
  endtask : scenEarlyWrite

  task automatic scenRegs();
    rdChk(ADDR_KEY, 32'h0);
    wr(ADDR_KEY, 8'h33);
    rdChk(ADDR_KEY, 32'h0);
    rdChk(32'h0000_0400, 32'h0);
    wr(ADDR_ADDR, 8'hff);
    rdChk(ADDR_ADDR, 32'h7f);
    wr(ADDR_CTRL, 8'hf0);
    rdChk(ADDR_CTRL, 32'h0);
  endtask : scenRegs

  task automatic scenGoodWrite();
    writeByte(8'h05, 8'h3c);
    wr(ADDR_CTRL, 8'h00); // drop permit and write zero to both triggers mid-write
    rdChk(ADDR_CTRL, 32'h2);
    waitIdle();
    chk(32'(busyCount - busyMark), 32'(WrCyc));
    chk({31'h0, writeDoneFlag}, 32'h1);
    rdChk(ADDR_CTRL, 32'h0);
    wr(ADDR_DATA, 8'h00);
    wr(ADDR_ADDR, 8'h85); // top bit set, still location 5
    wr(ADDR_CTRL, 8'h01);
    rdChk(ADDR_DATA, 32'h3c);
    rdChk(ADDR_CTRL, 32'h0);
    rdChk(ADDR_DATA, 32'h3c);
    rdChk(ADDR_PFLAG, 32'h80);
    wr(ADDR_PFLAG, 8'h00);
    rdChk(ADDR_PFLAG, 32'h0);
  endtask : scenGoodWrite

  // broken sequences: permit set with the trigger, interrupted keys, swapped keys
  task automatic scenBadSeq();
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_KEY, nv_access_pkg::KEY_FIRST);
    wr(ADDR_KEY, nv_access_pkg::KEY_SECOND);
    busyMark = busyCount;
    wr(ADDR_CTRL, 8'h06); // permit arrives too late for this trigger
    repeat (3) @(posedge clk);
    chk(32'(busyCount - busyMark), 32'h0);
    wr(ADDR_CTRL, 8'h04);
    wr(ADDR_KEY, nv_access_pkg::KEY_FIRST);
    rdChk(ADDR_DATA, 32'h3c);
    wr(ADDR_KEY, nv_access_pkg::KEY_SECOND);
    wr(ADDR_CTRL, 8'h06);
    repeat (3) @(posedge clk);
    chk(32'(busyCount - busyMark), 32'h0);
    wr(ADDR_KEY, nv_access_pkg::KEY_SECOND);
    wr(ADDR_KEY, nv_access_pkg::KEY_FIRST);
    wr(ADDR_CTRL, 8'h06);
    repeat (3) @(posedge clk);
    chk(32'(busyCount - busyMark), 32'h0);
    rdChk(ADDR_CTRL, 32'h4);
  endtask : scenBadSeq

  // each reset source cuts a running write short
  task automatic scenAbort();
    for (int src = 0; src < 3; src++) begin
      writeByte(8'h10 + 8'(src), 8'h5a);
      repeat (2) @(posedge clk);
      extRstN <= (src != 0);
      wdog <= (src == 1);
      brown <= (src == 2);
      repeat (4) @(posedge clk);
      extRstN <= 1'b1;
      wdog <= 1'b0;
      brown <= 1'b0;
      repeat (4) @(posedge clk);
      chk({31'h0, writeAbortFlag}, 32'h1);
      chk({31'h0, writeBusy}, 32'h0);
      rdChk(ADDR_CTRL, 32'h8);
      rdChk(ADDR_ADDR, 32'h0);
      rdChk(ADDR_DATA, 32'h0);
      wr(ADDR_CTRL, 8'h00);
      rdChk(ADDR_CTRL, 32'h0);
      // the cut write left its cell erased, never programmed
      wr(ADDR_ADDR, 8'h10 + 8'(src));
      wr(ADDR_CTRL, 8'h01);
      rdChk(ADDR_DATA, 32'hff);
    end
  endtask : scenAbort

  // main sequence
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    extRstN = 1'b1;
    wdog = 1'b0;
    brown = 1'b0;
    fail_count = 0;
    tests_run = 0;
    busyMark = 0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    scenEarlyWrite();
    repeat (PwrCyc) @(posedge clk);
    scenRegs();
    scenGoodWrite();
    scenBadSeq();
    scenAbort();
    summarize();
  end
endmodule : tb_top
